// [include/status_alarm_pkg.sv]
// How it works
// - Flag bit 5 shows overall self-test failure, zero when passing.
// - On failure flag bits 15..10 mark each failing axis.
// - Self-test runs about 35 ms; output data marked invalid meanwhile.
// - External stimulus is a static level; gyros both ways, accels positive only.
// - Read-only flash write counter, wraps to zero after 32768 counts.
// - Supply and overrange flags drop as soon as their condition ends.
// - Other flags stick until a flag register read; any read clears all.
// - Persisting conditions set their flags again at the next update cycle.
// - Bits 15..13 accel Z/Y/X, 12..10 gyro Z/Y/X, 9/8 alarm two/one.
// - Bit 4 overrange, bit 3 serial frame failure, bit 2 control update failure.
// - Bit 1 while supply above 5.25 V, bit 0 while below 4.75 V.
// - Two independent alarm channels compare their selected source data.
// - Threshold bit 15 picks greater or less; bits 13..0 hold the level.
// - Sample count bits 7..0 give the number of averaged deltas.
// - Rate mode averages successive sample deltas and compares the magnitude.
// - Alarms use filtered or raw data, static or rate mode, per alarm_control.
// - alarm_control 15..12 and 11..8 pick sources; zero disables the alarm.
// - alarm_control bit 2 drives a pin, bit 1 polarity, bit 0 line choice.
// - Self-test enable bit clears itself when the sequence ends.
// - Pin priority: data-ready first, then alarm, then general-purpose control.
package status_alarm_pkg;
  // ------------------------------------------------------------
  // Register offsets (byte addresses, even byte holds bits 7..0)
  // ------------------------------------------------------------
  localparam logic [6:0]  ADDR_FLASH_CNT = 7'h00;
  localparam logic [6:0]  ADDR_THR1      = 7'h26;
  localparam logic [6:0]  ADDR_THR2      = 7'h28;
  localparam logic [6:0]  ADDR_SMPL1     = 7'h2a;
  localparam logic [6:0]  ADDR_SMPL2     = 7'h2c;
  localparam logic [6:0]  ADDR_ALARM_CONTROL  = 7'h2e;
  localparam logic [6:0]  ADDR_MISC      = 7'h34;
  localparam logic [6:0]  ADDR_FLAGS     = 7'h3c;
  // ------------------------------------------------------------
  // Reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [15:0] THR_RST        = 16'h0000;
  localparam logic [15:0] SMPL_RST       = 16'h0000;
  localparam logic [15:0] ALARM_CONTROL_RST   = 16'h0000;
  localparam logic [15:0] MISC_RST       = 16'h0000;
  localparam logic [15:0] FLAGS_RST      = 16'h0000;
  localparam logic [15:0] THR_WMASK      = 16'hbfff;
  localparam logic [15:0] SMPL_WMASK     = 16'h00ff;
  localparam logic [15:0] ALARM_CONTROL_WMASK = 16'hffd7;
  localparam logic [15:0] MISC_WMASK     = 16'h07c7;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MISC_ST_BIT   = 10;
  localparam int MISC_NEG_BIT  = 9;
  localparam int MISC_POS_BIT  = 8;
  localparam int PIN_EN_BIT    = 2;
  localparam int PIN_POL_BIT   = 1;
  localparam int PIN_SEL_BIT   = 0;
  localparam int ALM_FILT_BIT  = 4;
  localparam int ALM_ROC1_BIT  = 6;
  localparam int ALM_SRC1_LSB  = 8;
  localparam int THR_DIR_BIT   = 15;
  localparam int FLG_LOW       = 0;
  localparam int FLG_HIGH      = 1;
  localparam int FLG_CTRL      = 2;
  localparam int FLG_SPI       = 3;
  localparam int FLG_OVR       = 4;
  localparam int FLG_ST        = 5;
  localparam int FLG_ALM1      = 8;
  localparam int FLG_AXIS_LSB  = 10;
  // ------------------------------------------------------------
  // Sizes and timing
  // ------------------------------------------------------------
  localparam int NUM_SRC       = 11;
  localparam int FLASH_CNT_W   = 15;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int CLK_HZ        = 25_000_000;
  localparam int ST_TIME_US    = 35_000;
  localparam int ST_CYCLES_DEF = ST_TIME_US * (CLK_HZ / 1_000_000);
endpackage

// [rtl/alarm_channel.sv]
`timescale 1ns/1ps
module alarm_channel #(
  parameter int DW = 14,
  parameter int NW = 8
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          tick,
  input  wire logic          enable,
  input  wire logic          rate_of_change,
  input  wire logic [DW-1:0] data,
  input  wire logic [15:0]   thr,
  input  wire logic [NW-1:0] smpl,
  output logic               hit
);
  import status_alarm_pkg::*;

  localparam int SW = DW + 1 + NW;

  typedef struct packed {
    logic [DW-1:0] prev;
    logic          primed;
    logic [SW-1:0] sum;
    logic [NW-1:0] cnt;
    logic          hit;
  } alm_s;

  alm_s s_reg;
  alm_s s_next;

  function automatic logic compare(input logic gt, input logic signed [SW:0] a,
                                   input logic signed [SW:0] b);
    return gt ? (a > b) : (a < b);
  endfunction

  logic [NW-1:0]        nds;
  logic signed [SW-1:0] sum_new;
  logic signed [SW-1:0] mag;

  // ------------------------------------------------------------
  // Static level and averaged rate of change
  // ------------------------------------------------------------
  always_comb begin
    s_next  = s_reg;
    nds     = (smpl == '0) ? NW'(1) : smpl;
    sum_new = $signed(s_reg.sum) + SW'($signed(data) - $signed(s_reg.prev));
    mag     = sum_new[SW-1] ? -sum_new : sum_new;
    if (!enable) begin
      s_next = '0;
    end else if (tick) begin
      if (!rate_of_change) begin
        s_next.hit    = compare(thr[THR_DIR_BIT], (SW+1)'($signed(data)),
                                (SW+1)'($signed(thr[DW-1:0])));
        s_next.primed = 1'b0;
        s_next.sum    = '0;
        s_next.cnt    = '0;
      end else if (!s_reg.primed) begin
        // First sample only seeds the delta chain
        s_next.prev   = data;
        s_next.primed = 1'b1;
      end else begin
        s_next.prev = data;
        if ({1'b0, s_reg.cnt} + (NW+1)'(1) >= {1'b0, nds}) begin
          // Sum compared to level times count, so no divider is needed
          s_next.hit = compare(thr[THR_DIR_BIT], (SW+1)'(mag),
                               (SW+1)'(thr[DW-1:0] * nds));
          s_next.sum = '0;
          s_next.cnt = '0;
        end else begin
          s_next.sum = sum_new;
          s_next.cnt = s_reg.cnt + NW'(1);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hit = s_reg.hit;

  property p_static_gt;
    @(posedge core_clk) disable iff (sys_rst)
    tick && enable && !rate_of_change && thr[THR_DIR_BIT] && ($signed(data) > $signed(thr[DW-1:0]))
    |=> hit;
  endproperty
  a_static_gt: assert property (p_static_gt) else $error("static alarm missed");

  property p_disabled;
    @(posedge core_clk) disable iff (sys_rst)
    !enable |=> !hit;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled alarm active");
endmodule

// [rtl/inertial_status_alarm_monitor.sv]
`timescale 1ns/1ps
module inertial_status_alarm_monitor
  import status_alarm_pkg::*;
#(
  parameter int ST_CYCLES = status_alarm_pkg::ST_CYCLES_DEF,
  parameter int DW        = 14
) (
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    spi_sclk,
  input  wire logic                    spi_cs_n,
  input  wire logic                    spi_mosi,
  output logic                         spi_miso,
  input  wire logic                    update_tick,
  input  wire logic [NUM_SRC-1:0][DW-1:0] src_raw,
  input  wire logic [NUM_SRC-1:0][DW-1:0] src_filt,
  input  wire logic                    flash_write,
  input  wire logic [5:0]              st_axis_fail,
  input  wire logic                    supply_high,
  input  wire logic                    supply_low,
  input  wire logic                    sensor_overrange,
  input  wire logic                    ctrl_update_fail,
  input  wire logic [1:0]              gpio_dir,
  input  wire logic [1:0]              gpio_level,
  output logic                         digital_line_one_out,
  output logic                         digital_line_one_oe,
  output logic                         digital_line_two_out,
  output logic                         digital_line_two_oe,
  output logic                         output_valid,
  output logic                         self_test_active,
  output logic                         gyro_stim_pos,
  output logic                         gyro_stim_neg,
  output logic                         accel_stim_pos
);
  import status_alarm_pkg::*;

  localparam int STW = $clog2(ST_CYCLES);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } st_e;

  typedef struct packed {
    st_e                    st;
    logic [STW-1:0]         st_cnt;
    logic [5:0]             st_fail;
    logic [15:0]            misc;
    logic [15:0]            actrl;
    logic [1:0][15:0]       thr;
    logic [1:0][15:0]       smpl;
    logic [FLASH_CNT_W-1:0] flash;
    logic [15:0]            flags;
    logic                   sclk_q;
    logic                   cs_q;
    logic [15:0]            rx;
    logic [15:0]            tx;
    logic [4:0]             bits;
    logic                   miso;
    logic                   tick_d;
    logic [1:0]             line_out;
    logic [1:0]             line_oe;
    logic                   valid;
    logic                   stact;
    logic [2:0]             stim;
  } mon_s;

  mon_s s_reg;
  mon_s s_next;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                           input logic [7:0] d, input logic [15:0] mask);
    logic [15:0] v;
    v = hi ? {d, old[7:0]} : {old[15:8], d};
    return (v & mask) | (old & ~mask);
  endfunction

  function automatic logic [DW-1:0] pick_src(input logic [3:0] code, input logic filt,
                                             input logic [NUM_SRC-1:0][DW-1:0] raw,
                                             input logic [NUM_SRC-1:0][DW-1:0] fil);
    logic [DW-1:0] v;
    v = '0;
    if (code != 4'h0 && 32'(code) <= NUM_SRC) begin
      v = filt ? fil[code - 4'h1] : raw[code - 4'h1];
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // Alarm channels
  // ------------------------------------------------------------
  logic [1:0] alm_hit;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_alm
      logic [3:0] code;
      assign code = s_reg.actrl[ALM_SRC1_LSB + 4*g +: 4];
      alarm_channel #(
        .DW (DW),
        .NW (8)
      ) u_alarm (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .tick     (update_tick & s_reg.valid),
        .enable   (code != 4'h0),
        .rate_of_change      (s_reg.actrl[ALM_ROC1_BIT + g]),
        .data     (pick_src(code, s_reg.actrl[ALM_FILT_BIT], src_raw, src_filt)),
        .thr      (s_reg.thr[g]),
        .smpl     (s_reg.smpl[g][7:0]),
        .hit      (alm_hit[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Serial port, registers, flags, self-test, pins
  // ------------------------------------------------------------
  logic        rise;
  logic        fall;
  logic        frame_done;
  logic        frame_err;
  logic        rd_status;
  logic [15:0] word;
  logic [6:0]  addr_even;
  logic [15:0] rd_word;
  logic        alarm_on;

  always_comb begin
    s_next     = s_reg;
    rise       = spi_sclk & ~s_reg.sclk_q;
    fall       = ~spi_sclk & s_reg.sclk_q;
    frame_done = 1'b0;
    frame_err  = 1'b0;
    rd_status  = 1'b0;
    word       = {s_reg.rx[14:0], spi_mosi};
    addr_even  = {word[14:9], 1'b0};
    s_next.sclk_q = spi_sclk;
    s_next.cs_q   = spi_cs_n;
    s_next.tick_d = update_tick;

    // Frame is sixteen bits, sampled on rising and shifted out on falling edges
    if (spi_cs_n) begin
      if (!s_reg.cs_q && s_reg.bits != FRAME_BITS) begin
        frame_err = 1'b1;
      end
      s_next.bits = 5'h00;
    end else begin
      if (rise) begin
        s_next.rx = word;
        if (s_reg.bits != 5'h1f) begin
          s_next.bits = s_reg.bits + 5'h01;
        end
        frame_done = (s_reg.bits == FRAME_LAST);
      end
      if (fall) begin
        s_next.miso = s_reg.tx[15];
        s_next.tx   = {s_reg.tx[14:0], 1'b0};
      end
    end

    case (addr_even)
      ADDR_FLASH_CNT: rd_word = {1'b0, s_reg.flash};
      ADDR_THR1:      rd_word = s_reg.thr[0];
      ADDR_THR2:      rd_word = s_reg.thr[1];
      ADDR_SMPL1:     rd_word = s_reg.smpl[0];
      ADDR_SMPL2:     rd_word = s_reg.smpl[1];
      ADDR_ALARM_CONTROL:  rd_word = s_reg.actrl;
      ADDR_MISC:      rd_word = s_reg.misc;
      ADDR_FLAGS:     rd_word = s_reg.flags;
      default:        rd_word = 16'h0000;
    endcase

    if (frame_done) begin
      if (word[15]) begin
        case (addr_even)
          ADDR_THR1:     s_next.thr[0]  = put_byte(s_reg.thr[0], word[8], word[7:0], THR_WMASK);
          ADDR_THR2:     s_next.thr[1]  = put_byte(s_reg.thr[1], word[8], word[7:0], THR_WMASK);
          ADDR_SMPL1:    s_next.smpl[0] = put_byte(s_reg.smpl[0], word[8], word[7:0],
                                                   SMPL_WMASK);
          ADDR_SMPL2:    s_next.smpl[1] = put_byte(s_reg.smpl[1], word[8], word[7:0],
                                                   SMPL_WMASK);
          ADDR_ALARM_CONTROL: s_next.actrl   = put_byte(s_reg.actrl, word[8], word[7:0],
                                                   ALARM_CONTROL_WMASK);
          ADDR_MISC:     s_next.misc    = put_byte(s_reg.misc, word[8], word[7:0],
                                                   MISC_WMASK);
          default:       s_next.misc    = s_reg.misc;
        endcase
      end else begin
        // Answer goes out during the next frame
        s_next.tx = rd_word;
        rd_status = (addr_even == ADDR_FLAGS);
      end
    end

    // Flash counter is read-only and wraps by width
    if (flash_write) begin
      s_next.flash = s_reg.flash + FLASH_CNT_W'(1);
    end

    // Self-test sequence
    case (s_reg.st)
      ST_IDLE: begin
        if (s_next.misc[MISC_ST_BIT]) begin
          s_next.st     = ST_RUN;
          s_next.st_cnt = '0;
        end
      end
      ST_RUN: begin
        // A write cannot abort the sequence early
        s_next.misc[MISC_ST_BIT] = 1'b1;
        s_next.st_cnt = s_reg.st_cnt + STW'(1);
        if (s_reg.st_cnt == STW'(ST_CYCLES - 1)) begin
          s_next.st                = ST_IDLE;
          s_next.misc[MISC_ST_BIT] = 1'b0;
          s_next.st_fail           = st_axis_fail;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase

    // Flags: clear first so that any set in the same cycle wins
    if (rd_status) begin
      s_next.flags = FLAGS_RST;
    end
    if (!supply_high) begin
      s_next.flags[FLG_HIGH] = 1'b0;
    end
    if (!supply_low) begin
      s_next.flags[FLG_LOW] = 1'b0;
    end
    if (!sensor_overrange) begin
      s_next.flags[FLG_OVR] = 1'b0;
    end
    if (frame_err) begin
      s_next.flags[FLG_SPI] = 1'b1;
    end
    if (ctrl_update_fail) begin
      s_next.flags[FLG_CTRL] = 1'b1;
    end
    if (update_tick) begin
      s_next.flags[FLG_HIGH] = s_next.flags[FLG_HIGH] | supply_high;
      s_next.flags[FLG_LOW]  = s_next.flags[FLG_LOW] | supply_low;
      s_next.flags[FLG_OVR]  = s_next.flags[FLG_OVR] | sensor_overrange;
      s_next.flags[15:FLG_AXIS_LSB] = s_next.flags[15:FLG_AXIS_LSB] | s_reg.st_fail;
      s_next.flags[FLG_ST]   = s_next.flags[FLG_ST] | (|s_reg.st_fail);
    end
    if (s_reg.st == ST_RUN && s_next.st == ST_IDLE) begin
      s_next.flags[15:FLG_AXIS_LSB] = s_next.flags[15:FLG_AXIS_LSB] | st_axis_fail;
      s_next.flags[FLG_ST]   = s_next.flags[FLG_ST] | (|st_axis_fail);
    end
    if (s_reg.tick_d) begin
      // Hit is updated in the cycle after the tick
      s_next.flags[FLG_ALM1 +: 2] = s_next.flags[FLG_ALM1 +: 2] | alm_hit;
    end
    s_next.flags[7:6] = 2'b00;

    // Pins: later assignments override earlier ones
    alarm_on = |alm_hit;
    for (int i = 0; i < 2; i++) begin
      s_next.line_oe[i]  = gpio_dir[i];
      s_next.line_out[i] = gpio_dir[i] & gpio_level[i];
      if (s_reg.actrl[PIN_EN_BIT] && s_reg.actrl[PIN_SEL_BIT] == 1'(i)) begin
        s_next.line_oe[i]  = 1'b1;
        s_next.line_out[i] = ~(alarm_on ^ s_reg.actrl[PIN_POL_BIT]);
      end
      if (s_reg.misc[PIN_EN_BIT] && s_reg.misc[PIN_SEL_BIT] == 1'(i)) begin
        s_next.line_oe[i]  = 1'b1;
        s_next.line_out[i] = ~((s_reg.tick_d & s_reg.valid) ^ s_reg.misc[PIN_POL_BIT]);
      end
    end

    s_next.stact = (s_next.st == ST_RUN);
    s_next.valid = (s_next.st != ST_RUN);
    // Accelerometers take only the positive stimulus
    s_next.stim  = {s_next.misc[MISC_POS_BIT], s_next.misc[MISC_NEG_BIT],
                    s_next.misc[MISC_POS_BIT]};
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_reg          <= '0;
      s_reg.st       <= ST_IDLE;
      s_reg.misc     <= MISC_RST;
      s_reg.actrl    <= ALARM_CONTROL_RST;
      s_reg.thr      <= {THR_RST, THR_RST};
      s_reg.smpl     <= {SMPL_RST, SMPL_RST};
      s_reg.flags    <= FLAGS_RST;
      s_reg.sclk_q   <= 1'b1;
      s_reg.cs_q     <= 1'b1;
      s_reg.valid    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign spi_miso             = s_reg.miso;
  assign digital_line_one_out = s_reg.line_out[0];
  assign digital_line_one_oe  = s_reg.line_oe[0];
  assign digital_line_two_out = s_reg.line_out[1];
  assign digital_line_two_oe  = s_reg.line_oe[1];
  assign output_valid         = s_reg.valid;
  assign self_test_active     = s_reg.stact;
  assign accel_stim_pos       = s_reg.stim[2];
  assign gyro_stim_neg        = s_reg.stim[1];
  assign gyro_stim_pos        = s_reg.stim[0];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_st_end;
    $fell(self_test_active);
  endsequence

  property p_st_valid;
    @(posedge core_clk) disable iff (sys_rst)
    self_test_active |-> !output_valid;
  endproperty
  a_st_valid: assert property (p_st_valid) else $error("data valid during self-test");

  property p_st_clear;
    @(posedge core_clk) disable iff (sys_rst)
    s_st_end |-> !s_reg.misc[MISC_ST_BIT];
  endproperty
  a_st_clear: assert property (p_st_clear) else $error("self-test bit not cleared");

  property p_st_fail;
    @(posedge core_clk) disable iff (sys_rst)
    s_st_end ##0 (|s_reg.st_fail) |-> s_reg.flags[FLG_ST];
  endproperty
  a_st_fail: assert property (p_st_fail) else $error("self-test failure not flagged");

  property p_wrap;
    @(posedge core_clk) disable iff (sys_rst)
    flash_write && (&s_reg.flash) |=> s_reg.flash == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("flash counter did not wrap");

  property p_read_clear;
    @(posedge core_clk) disable iff (sys_rst)
    rd_status && !update_tick && !s_reg.tick_d && !frame_err && !ctrl_update_fail
    && !(s_reg.st == ST_RUN && s_next.st == ST_IDLE) |=> s_reg.flags == 16'h0000;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag read did not clear");

  property p_supply_drop;
    @(posedge core_clk) disable iff (sys_rst)
    !supply_high && !update_tick |=> !s_reg.flags[FLG_HIGH];
  endproperty
  a_supply_drop: assert property (p_supply_drop) else $error("high supply flag stuck");

  property p_supply_low;
    @(posedge core_clk) disable iff (sys_rst)
    update_tick && supply_low |=> s_reg.flags[FLG_LOW];
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("low supply not flagged");

  property p_unused;
    @(posedge core_clk) disable iff (sys_rst)
    s_reg.flags[7:6] == 2'b00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused flag bits set");

  property p_alarm_flag;
    @(posedge core_clk) disable iff (sys_rst)
    s_reg.tick_d && alm_hit[0] |=> s_reg.flags[FLG_ALM1];
  endproperty
  a_alarm_flag: assert property (p_alarm_flag) else $error("alarm one not flagged");
endmodule

// [verif/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic        core_clk,
  input  wire logic        spi_miso,
  output logic             spi_sclk,
  output logic             spi_cs_n,
  output logic             spi_mosi,
  output logic [15:0]      rx,
  output logic             done
);
  initial begin
    {spi_sclk, spi_cs_n, spi_mosi, done, rx} = {2'h3, 1'h0, 1'h0, 16'h0000};
  end
  // Two core clocks per phase keep sclk slow enough to be sampled
  task automatic frame(input logic [15:0] w);
    @(posedge core_clk) spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (2) @(posedge core_clk);
      spi_sclk <= 1'b0;
      spi_mosi <= w[i];
      repeat (2) @(posedge core_clk);
      spi_sclk <= 1'b1;
      rx[i] <= spi_miso;
    end
    repeat (2) @(posedge core_clk);
    spi_cs_n <= 1'b1;
    // Released data line must not keep showing the last bit
    spi_mosi <= ~spi_mosi;
    done <= 1'b1;
    @(posedge core_clk) done <= 1'b0;
  endtask
  // Select dropped again with no clock edge: a cut frame
  task automatic cut;
    @(posedge core_clk) spi_cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    spi_cs_n <= 1'b1;
  endtask
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  import status_alarm_pkg::*;
  logic core_clk, sys_rst, update_tick, flash_write, supply_high, supply_low;
  logic sensor_overrange, ctrl_update_fail, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
  logic digital_line_one_out, digital_line_one_oe, output_valid, done;
  logic digital_line_two_out, digital_line_two_oe, self_test_active;
  logic gyro_stim_pos, gyro_stim_neg, accel_stim_pos;
  logic [NUM_SRC-1:0][13:0] src_raw;
  logic [NUM_SRC-1:0][13:0] src_filt;
  logic [5:0]               st_axis_fail;
  logic [15:0]              rx;
  int                       n_mismatch = 0;
  int                       compares = 0;
  int                       e;
  int                       expq[$];
  inertial_status_alarm_monitor #(.ST_CYCLES(20)) uut (.core_clk, .sys_rst, .spi_sclk,
    .spi_cs_n, .spi_mosi, .spi_miso, .update_tick, .src_raw, .src_filt, .flash_write,
    .st_axis_fail, .supply_high, .supply_low, .sensor_overrange, .ctrl_update_fail,
    .gpio_dir(2'h0), .gpio_level(2'h0), .digital_line_one_out, .digital_line_one_oe,
    .digital_line_two_out, .digital_line_two_oe, .output_valid, .self_test_active,
    .gyro_stim_pos, .gyro_stim_neg, .accel_stim_pos);
  spi_host_model host (.core_clk, .spi_miso, .spi_sclk, .spi_cs_n, .spi_mosi, .rx, .done);
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic results;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(string n, logic [15:0] x, logic [15:0] s);
    compares++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  // Pulse kinds: 0 update tick, 1 flash write, 2 control update failure
  task automatic pulse(int k);
    @(posedge core_clk);
    if (k == 0) update_tick <= 1'b1;
    else if (k == 1) flash_write <= 1'b1;
    else ctrl_update_fail <= 1'b1;
    @(posedge core_clk);
    {update_tick, flash_write, ctrl_update_fail} <= 3'h0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    expq.push_back(-1);
    host.frame({1'b1, a, d});
  endtask
  // Read data comes back in the frame after the command
  task automatic rd(logic [6:0] a, int x);
    expq.push_back(-1);
    host.frame({1'b0, a, 8'h00});
    expq.push_back(x);
    host.frame(16'h0000);
  endtask
  always @(posedge core_clk) begin
    if (done === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      if (e >= 0) cmp("spi_read", 16'(e), rx);
    end
  end
  initial begin
    repeat (50000) @(posedge core_clk);
    n_mismatch++;
    results();
  end
  initial begin
    {update_tick, flash_write, ctrl_update_fail, supply_high, supply_low} = '0;
    {sensor_overrange, sys_rst, src_raw, st_axis_fail} = {2'h1, 154'h0, 6'h00};
    src_filt = '0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    void'($urandom(53956));
    foreach (src_raw[i]) src_raw[i] <= 14'($urandom_range(99));
    foreach (src_filt[i]) src_filt[i] <= 14'($urandom_range(99));
    sensor_overrange <= 1'b0;
    rd(ADDR_FLAGS, 0);
    rd(ADDR_THR2, 0);
    repeat (3) pulse(1);
    wr(ADDR_FLASH_CNT, 8'h55);
    rd(ADDR_FLASH_CNT, 3);
    // One full lap of writes must bring the counter back to the same value
    flash_write <= 1'b1;
    repeat (32768) @(posedge core_clk);
    flash_write <= 1'b0;
    rd(ADDR_FLASH_CNT, 3);
    supply_high <= 1'b1;
    pulse(0);
    rd(ADDR_FLAGS, 16'h0002);
    pulse(0);
    rd(ADDR_FLAGS, 16'h0002);
    {supply_high, supply_low} <= 2'h1;
    pulse(0);
    rd(ADDR_FLAGS, 16'h0001);
    supply_low <= 1'b0;
    pulse(0);
    rd(ADDR_FLAGS, 0);
    pulse(2);
    pulse(0);
    rd(ADDR_FLAGS, 16'h0004);
    rd(ADDR_FLAGS, 0);
    host.cut();
    rd(ADDR_FLAGS, 16'h0008);
    sensor_overrange <= 1'b1;
    pulse(0);
    rd(ADDR_FLAGS, 16'h0010);
    sensor_overrange <= 1'b0;
    wr(ADDR_THR1, 8'h64);
    wr(ADDR_THR1 + 7'h1, 8'hff);
    rd(ADDR_THR1, 16'hbf64);
    wr(ADDR_THR1 + 7'h1, 8'h80);
    src_raw[0] <= 14'd200;
    wr(ADDR_ALARM_CONTROL, 8'h06);
    wr(ADDR_ALARM_CONTROL + 7'h1, 8'h01);
    pulse(0);
    cmp("line_one", 2'h3, {digital_line_one_oe, digital_line_one_out});
    rd(ADDR_FLAGS, 16'h0100);
    // Alarm moved to line two, active low; data-ready then takes the line over
    wr(ADDR_ALARM_CONTROL, 8'h05);
    cmp("line_one", 2'h0, {digital_line_one_oe, digital_line_one_out});
    cmp("line_two", 2'h2, {digital_line_two_oe, digital_line_two_out});
    wr(ADDR_MISC, 8'h05);
    cmp("line_two", 2'h3, {digital_line_two_oe, digital_line_two_out});
    wr(ADDR_MISC, 8'h00);
    wr(ADDR_MISC + 7'h1, 8'h02);
    cmp("stimulus", 3'h2, {accel_stim_pos, gyro_stim_neg, gyro_stim_pos});
    wr(ADDR_MISC + 7'h1, 8'h01);
    cmp("stimulus", 3'h5, {accel_stim_pos, gyro_stim_neg, gyro_stim_pos});
    // Alarm two on filtered data in rate mode: deltas of 15 against a level of 10
    wr(ADDR_THR2, 8'h0a);
    wr(ADDR_THR2 + 7'h1, 8'h80);
    wr(ADDR_SMPL2, 8'h02);
    src_filt[1] <= 14'd0;
    wr(ADDR_ALARM_CONTROL, 8'h90);
    wr(ADDR_ALARM_CONTROL + 7'h1, 8'h20);
    pulse(0);
    src_filt[1] <= 14'd15;
    pulse(0);
    src_filt[1] <= 14'd30;
    pulse(0);
    rd(ADDR_FLAGS, 16'h0200);
    st_axis_fail <= 6'($urandom_range(63, 1));
    wr(ADDR_MISC + 7'h1, 8'h04);
    cmp("output_valid", 1'b0, output_valid);
    cmp("self_test", 1'b1, self_test_active);
    repeat (30) @(posedge core_clk);
    cmp("output_valid", 1'b1, output_valid);
    cmp("self_test", 1'b0, self_test_active);
    rd(ADDR_FLAGS, {st_axis_fail, 10'h020});
    rd(ADDR_MISC, 0);
    results();
  end
endmodule
